// >>> src/csp_position_ref.sv
`timescale 1ns/100ps
`include "csp_defines.svh"

// Behaviour
// - Mode 15 runs proportional position loop plus feed-forward from external profile.
// - Feedback select bit 0 uses resolver, 1 uses encoder.
// - Speed request is loop output plus feed-forward, feed-forward clamped to 9000.
// - Sync copies received feed-forward into active feed-forward.
// - Sync copies received 32-bit position reference into loop reference.
// - Sync copies motor position into the reply value.
// - Master sync sets the flag; device does copies then clears it.
// - Type 0 sync with type-0 transmit enable sends reply value.
// - Type 1 sync with type-1 transmit enable sends reply value.
// - Reply status is full 16 bits, or low byte when select set.
// - Bit-rate parameter zero: 500k with low-speed bit, else 1M.
// - Zero reset clears motor position and reference.
// - Preset reset loads both with shaft preset, clears auxiliary counter.
// - Follow reset copies motor position to reference, clears auxiliary counter.
// - Cam one global enable adds cam one output to global counter.
// - Cam two global enable adds cam two output to global counter.
// - Positioner global enable adds positioner output to global counter.
// - Three enables route cam and positioner outputs into loop reference.
// - Writable virtual table enable, reset to zero.
// - Cam two select bits 11,10,01,00 pick tables 0,1,2,3.

// ----------------------------------------
// Reply FIFO
// ----------------------------------------
module csp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    // Extra pointer bit tells full from empty
    assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_q[AW-1:0]];

    // Storage has no reset; only pointers matter
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------
// Position reference block
// ----------------------------------------
module csp_position_ref
    import csp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [3:0]  operating_mode,
    input  wire logic        par_wr,
    input  wire logic        par_rd,
    input  wire logic [7:0]  par_addr,
    input  wire logic [15:0] par_wdata,
    output logic      [15:0] par_rdata,
    output logic             par_rvalid,
    input  wire logic        can_sync_valid,
    input  wire logic        can_sync_type,
    input  wire logic [31:0] resolver_pos,
    input  wire logic [31:0] encoder_pos,
    input  wire logic [31:0] first_cam_generator_delta,
    input  wire logic [31:0] cam2_delta,
    input  wire logic [31:0] positioner_delta,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [31:0] tx_data,
    output logic      [15:0] speed_request_value,
    output logic      [15:0] reply_status,
    output logic             reply_status_byte,
    output logic      [1:0]  bitrate_code,
    output logic      [1:0]  cam2_table_sel,
    output logic             virtual_table_enable,
    output logic             sync_latch_flag
);

    csp_regs_t q;
    csp_regs_t d;
    logic      fifo_in_valid;
    logic      fifo_in_ready;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Feed-forward clamp
    function automatic logic [15:0] clamp_ffw(input logic signed [31:0] v);
        if (v > `CSP_FFW_LIMIT) begin
            clamp_ffw = 16'(`CSP_FFW_LIMIT);
        end else if (v < -`CSP_FFW_LIMIT) begin
            clamp_ffw = 16'(-`CSP_FFW_LIMIT);
        end else begin
            clamp_ffw = v[15:0];
        end
    endfunction

    // Saturate to a signed 16-bit word
    function automatic logic [15:0] sat16(input logic signed [31:0] v);
        if (v > 32'sd32767) begin
            sat16 = 16'h7fff;
        end else if (v < -32'sd32768) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    // Sign-extend a 16-bit value
    function automatic logic [31:0] sx16(input logic [15:0] v);
        sx16 = {{16{v[15]}}, v};
    endfunction

    // Parameter read mux; unknown numbers read zero
    function automatic logic [15:0] read_par(input csp_regs_t s, input logic [7:0] a);
        case (a)
            `CSP_PAR_PRESET:   read_par = s.preset;
            `CSP_PAR_BITRATE:  read_par = s.brate;
            `CSP_PAR_REF_LO:   read_par = s.lref[15:0];
            `CSP_PAR_REF_HI:   read_par = s.lref[31:16];
            `CSP_PAR_MPOS_LO:  read_par = s.mpos[15:0];
            `CSP_PAR_MPOS_HI:  read_par = s.mpos[31:16];
            `CSP_PAR_AUX_LO:   read_par = s.aux[15:0];
            `CSP_PAR_AUX_HI:   read_par = s.aux[31:16];
            `CSP_PAR_SPEED:    read_par = s.spd;
            `CSP_PAR_FBCFG:    read_par = s.fbcfg;
            `CSP_PAR_CMD:      read_par = s.cmd;
            `CSP_PAR_STATUS:   read_par = s.status;
            `CSP_PAR_FFW_ACT:  read_par = s.ffw_act;
            `CSP_PAR_FFW_RX:   read_par = s.ffw_rx;
            `CSP_PAR_PREF_LO:  read_par = s.pref_rx[15:0];
            `CSP_PAR_PREF_HI:  read_par = s.pref_rx[31:16];
            `CSP_PAR_REPLY_LO: read_par = s.reply[15:0];
            `CSP_PAR_REPLY_HI: read_par = s.reply[31:16];
            `CSP_PAR_GLOB_LO:  read_par = s.glob[15:0];
            `CSP_PAR_GLOB_HI:  read_par = s.glob[31:16];
            `CSP_PAR_SYNCCTL:  read_par = s.ctl;
            `CSP_PAR_CAMCTL:   read_par = s.cam;
            `CSP_PAR_GAIN:     read_par = s.gain;
            default:           read_par = 16'h0000;
        endcase
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic [31:0]        res_dlt;
        logic [31:0]        enc_dlt;
        logic [31:0]        fb_dlt;
        logic [31:0]        ref_add;
        logic [31:0]        glb_add;
        logic signed [31:0] err;
        logic signed [31:0] loop_out;
        logic               tx_need;
        d             = q;
        res_dlt       = resolver_pos - q.res_prev;
        enc_dlt       = encoder_pos - q.enc_prev;
        fb_dlt        = '0;
        ref_add       = '0;
        glb_add       = '0;
        err           = '0;
        loop_out      = '0;
        tx_need       = 1'b0;
        fifo_in_valid = 1'b0;
        d.rvalid      = 1'b0;
        d.res_prev    = resolver_pos;
        d.enc_prev    = encoder_pos;

        // Motor count follows the selected feedback; aux follows the encoder
        fb_dlt = q.fbcfg[`CSP_FB_SEL_BIT] ? enc_dlt : res_dlt;
        d.mpos = q.mpos + fb_dlt;
        d.aux  = q.aux + enc_dlt;

        // Generator outputs into the global counter
        if (q.cam[`CSP_FIRST_CAM_GENERATOR_GLB_BIT]) begin
            glb_add = glb_add + first_cam_generator_delta;
        end
        if (q.cam[`CSP_CAM2_GLB_BIT]) begin
            glb_add = glb_add + cam2_delta;
        end
        if (q.cam[`CSP_POS_GLB_BIT]) begin
            glb_add = glb_add + positioner_delta;
        end
        d.glob = q.glob + glb_add;

        // Generator outputs into the loop reference
        if (q.cam[`CSP_FIRST_CAM_GENERATOR_REF_BIT]) begin
            ref_add = ref_add + first_cam_generator_delta;
        end
        if (q.cam[`CSP_CAM2_REF_BIT]) begin
            ref_add = ref_add + cam2_delta;
        end
        if (q.cam[`CSP_POS_REF_BIT]) begin
            ref_add = ref_add + positioner_delta;
        end
        d.lref = q.lref + ref_add;

        // Position resets; only the lowest set bit acts, all three bits clear
        if (q.ctl[`CSP_RST_ZERO_BIT]) begin
            d.mpos = '0;
            d.lref = '0;
        end else if (q.ctl[`CSP_RST_PRESET_BIT]) begin
            d.mpos = sx16(q.preset);
            d.lref = sx16(q.preset);
            d.aux  = '0;
        end else if (q.ctl[`CSP_RST_FOLLOW_BIT]) begin
            d.lref = q.mpos;
            d.aux  = '0;
        end
        d.ctl[`CSP_RST_ZERO_BIT]   = 1'b0;
        d.ctl[`CSP_RST_PRESET_BIT] = 1'b0;
        d.ctl[`CSP_RST_FOLLOW_BIT] = 1'b0;

        // Sync sequencer; a full reply FIFO holds the flag until room appears
        tx_need = q.tx_req;
        unique case (q.fsm)
            CSP_ST_IDLE, CSP_ST_WAIT: begin
                d.fsm = CSP_ST_IDLE;
                if (q.ctl[`CSP_SYNC_BIT]) begin
                    if (!tx_need || fifo_in_ready) begin
                        d.ffw_act                = q.ffw_rx;
                        d.lref                   = q.pref_rx;
                        d.reply                  = q.mpos;
                        fifo_in_valid            = tx_need;
                        d.tx_req                 = 1'b0;
                        d.ctl[`CSP_SYNC_BIT]     = 1'b0;
                    end else begin
                        d.fsm = CSP_ST_WAIT;
                    end
                end
            end
        endcase

        // Parameter writes
        if (par_wr) begin
            case (par_addr)
                `CSP_PAR_PRESET:   d.preset       = par_wdata;
                `CSP_PAR_BITRATE:  d.brate        = par_wdata;
                `CSP_PAR_FBCFG:    d.fbcfg        = par_wdata;
                `CSP_PAR_CMD:      d.cmd          = par_wdata;
                `CSP_PAR_STATUS:   d.status       = par_wdata;
                `CSP_PAR_FFW_ACT:  d.ffw_act      = clamp_ffw(sx16(par_wdata));
                `CSP_PAR_FFW_RX:   d.ffw_rx       = clamp_ffw(sx16(par_wdata));
                `CSP_PAR_PREF_LO:  d.pref_rx[15:0]  = par_wdata;
                `CSP_PAR_PREF_HI:  d.pref_rx[31:16] = par_wdata;
                `CSP_PAR_REPLY_LO: d.reply[15:0]    = par_wdata;
                `CSP_PAR_REPLY_HI: d.reply[31:16]   = par_wdata;
                `CSP_PAR_SYNCCTL:  d.ctl          = par_wdata;
                `CSP_PAR_CAMCTL:   d.cam          = par_wdata;
                `CSP_PAR_GAIN:     d.gain         = par_wdata;
                default:           d.rvalid       = 1'b0;
            endcase
        end

        // Master sync arrives last so it wins over a clearing write
        if (can_sync_valid) begin
            d.ctl[`CSP_SYNC_BIT] = 1'b1;
            d.tx_req = can_sync_type ? q.ctl[`CSP_TX1_EN_BIT]
                                     : q.ctl[`CSP_TX0_EN_BIT];
        end

        // Proportional loop; gain is a right shift to keep it multiplier-free
        err      = $signed(q.lref - q.mpos);
        loop_out = err >>> q.gain[4:0];
        if (operating_mode == `CSP_OPM_CAN_POS) begin
            d.spd = sat16(loop_out + $signed(sx16(q.ffw_act)));
        end else begin
            d.spd = 16'h0000;
        end

        // Reply status width
        d.rstat = q.ctl[`CSP_REPLY_W_BIT] ? {8'h00, q.status[7:0]} : q.status;

        // Real-time bit rate
        if (q.brate == 16'h0000) begin
            d.rate = q.ctl[`CSP_LOWRATE_BIT] ? `CSP_RATE_500K : `CSP_RATE_1M;
        end else begin
            d.rate = `CSP_RATE_PARAM;
        end

        // Registered read answer
        if (par_rd) begin
            d.rdata  = read_par(q, par_addr);
            d.rvalid = 1'b1;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q       <= '0;
            q.fsm   <= CSP_ST_IDLE;
            q.gain  <= `CSP_GAIN_RESET;
            q.rate  <= `CSP_RATE_1M;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Reply FIFO toward the CAN transmitter
    // ----------------------------------------
    csp_fifo #(
        .WIDTH (32),
        .DEPTH (`CSP_FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (q.mpos),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign par_rdata            = q.rdata;
    assign par_rvalid           = q.rvalid;
    assign speed_request_value  = q.spd;
    assign reply_status         = q.rstat;
    assign reply_status_byte    = q.ctl[`CSP_REPLY_W_BIT];
    assign bitrate_code         = q.rate;
    assign cam2_table_sel       = ~{q.cam[`CSP_TSEL_A_BIT], q.cam[`CSP_TSEL_B_BIT]};
    assign virtual_table_enable = q.cam[`CSP_VTAB_BIT];
    assign sync_latch_flag      = q.ctl[`CSP_SYNC_BIT];

endmodule

// >>> src/csp_defines.svh
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH

// ----------------------------------------
// Parameter numbers on the parameter port
// ----------------------------------------
`define CSP_PAR_PRESET      8'd28
`define CSP_PAR_BITRATE     8'd48
`define CSP_PAR_REF_LO      8'd60
`define CSP_PAR_REF_HI      8'd61
`define CSP_PAR_MPOS_LO     8'd62
`define CSP_PAR_MPOS_HI     8'd63
`define CSP_PAR_AUX_LO      8'd64
`define CSP_PAR_AUX_HI      8'd65
`define CSP_PAR_SPEED       8'd6
`define CSP_PAR_FBCFG       8'd70
`define CSP_PAR_CMD         8'd102
`define CSP_PAR_STATUS      8'd103
`define CSP_PAR_FFW_ACT     8'd104
`define CSP_PAR_FFW_RX      8'd105
`define CSP_PAR_PREF_LO     8'd114
`define CSP_PAR_PREF_HI     8'd115
`define CSP_PAR_REPLY_LO    8'd116
`define CSP_PAR_REPLY_HI    8'd117
`define CSP_PAR_GLOB_LO     8'd130
`define CSP_PAR_GLOB_HI     8'd131
`define CSP_PAR_SYNCCTL     8'd150
`define CSP_PAR_CAMCTL      8'd181
`define CSP_PAR_GAIN        8'd190

// ----------------------------------------
// Bit positions
// ----------------------------------------
`define CSP_FB_SEL_BIT      1
`define CSP_TX0_EN_BIT      2
`define CSP_REPLY_W_BIT     3
`define CSP_LOWRATE_BIT     4
`define CSP_TX1_EN_BIT      6
`define CSP_SYNC_BIT        8
`define CSP_RST_ZERO_BIT    10
`define CSP_RST_PRESET_BIT  11
`define CSP_RST_FOLLOW_BIT  12
`define CSP_TSEL_A_BIT      6
`define CSP_TSEL_B_BIT      7
`define CSP_VTAB_BIT        8
`define CSP_FIRST_CAM_GENERATOR_GLB_BIT    9
`define CSP_CAM2_GLB_BIT    10
`define CSP_POS_GLB_BIT     11
`define CSP_FIRST_CAM_GENERATOR_REF_BIT    13
`define CSP_CAM2_REF_BIT    14
`define CSP_POS_REF_BIT     15

// ----------------------------------------
// Values
// ----------------------------------------
`define CSP_OPM_CAN_POS     4'hf
`define CSP_FFW_LIMIT       32'sd9000
`define CSP_GAIN_RESET      16'h0004
`define CSP_FIFO_DEPTH      32
`define CSP_RATE_PARAM      2'h0
`define CSP_RATE_1M         2'h1
`define CSP_RATE_500K       2'h2

`endif

// >>> src/csp_pkg.sv
package csp_pkg;

    // Sync sequencer states, one-hot
    typedef enum logic [1:0] {
        CSP_ST_IDLE = 2'b01,
        CSP_ST_WAIT = 2'b10
    } csp_state_t;

    // Whole state of the top module
    typedef struct packed {
        csp_state_t  fsm;
        logic [15:0] cmd;
        logic [15:0] status;
        logic [15:0] ffw_act;
        logic [15:0] ffw_rx;
        logic [31:0] pref_rx;
        logic [31:0] reply;
        logic [15:0] ctl;
        logic [15:0] cam;
        logic [15:0] fbcfg;
        logic [15:0] brate;
        logic [15:0] preset;
        logic [15:0] gain;
        logic [31:0] lref;
        logic [31:0] mpos;
        logic [31:0] aux;
        logic [31:0] glob;
        logic [31:0] res_prev;
        logic [31:0] enc_prev;
        logic        tx_req;
        logic [15:0] spd;
        logic [15:0] rstat;
        logic [1:0]  rate;
        logic [15:0] rdata;
        logic        rvalid;
    } csp_regs_t;

endpackage

// >>> tb/csp_position_ref_asserts.sv
`timescale 1ns/100ps
// --------
// Port checks
// --------
module csp_position_ref_asserts (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic [3:0]  operating_mode,
    input wire logic        par_wr,
    input wire logic        par_rd,
    input wire logic [7:0]  par_addr,
    input wire logic [15:0] par_wdata,
    input wire logic        par_rvalid,
    input wire logic        can_sync_valid,
    input wire logic        tx_valid,
    input wire logic [15:0] speed_request_value,
    input wire logic [15:0] reply_status,
    input wire logic        reply_status_byte,
    input wire logic [1:0]  cam2_table_sel,
    input wire logic        virtual_table_enable,
    input wire logic        sync_latch_flag
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // Sync taken, flag up one cycle later
    sequence s_sync_taken;
        can_sync_valid ##1 sync_latch_flag;
    endsequence
    // Write to cam control
    sequence s_cam_write;
        par_wr && par_addr == 8'hb5;
    endsequence

    a_rd_answer:
        assert property (par_rd |=> par_rvalid) else $error("read not answered");
    a_rvalid_cause:
        assert property (par_rvalid |-> $past(par_rd)) else $error("answer without read");
    a_sync_flag_set:
        assert property (can_sync_valid |=> sync_latch_flag) else $error("sync flag not set");
    // Flag may only linger while the reply queue holds words
    a_sync_flag_clear:
        assert property (s_sync_taken ##0 !can_sync_valid |=> !sync_latch_flag || tx_valid)
        else $error("sync flag stuck");
    a_wr_sync_start:
        assert property (par_wr && par_addr == 8'h96 && par_wdata[8] |=> sync_latch_flag)
        else $error("written sync lost");
    a_reply_byte:
        assert property (reply_status_byte && $past(reply_status_byte) |-> reply_status[15:8] == 8'h00)
        else $error("reply status not one byte");
    a_speed_idle:
        assert property (operating_mode != 4'hf |=> speed_request_value == 16'h0000)
        else $error("speed request outside loop mode");
    a_table_map:
        assert property (s_cam_write |=> cam2_table_sel == ~{$past(par_wdata[6]), $past(par_wdata[7])})
        else $error("cam two table wrong");
    a_vtab_write:
        assert property (s_cam_write |=> virtual_table_enable == $past(par_wdata[8]))
        else $error("virtual table enable not written");
    a_vtab_hold:
        assert property (!(par_wr && par_addr == 8'hb5) |=> $stable(virtual_table_enable))
        else $error("virtual table enable moved");
endmodule

bind csp_position_ref csp_position_ref_asserts chk_u (
    .mclk, .resetn, .operating_mode, .par_wr, .par_rd, .par_addr, .par_wdata, .par_rvalid, .can_sync_valid,
    .tx_valid, .speed_request_value, .reply_status, .reply_status_byte, .cam2_table_sel, .virtual_table_enable,
    .sync_latch_flag
);

// >>> tb/csp_can_master.sv
`timescale 1ns/100ps
// --------
// Profile master model
// --------
module csp_can_master (
    input  wire logic        mclk,
    input  wire logic        tx_valid,
    input  wire logic [31:0] tx_data,
    output logic             can_sync_valid,
    output logic             can_sync_type,
    output logic             tx_ready
);
    int          words = 0;
    logic [31:0] last_word = 32'h0000_0000;
    logic        stall = 1'b0;

    // Idle: no sync; ready comes from the stall process only
    initial begin
        can_sync_valid = 1'b0;
        can_sync_type  = 1'b0;
    end

    // One sync frame, one cycle wide
    task automatic send_sync(input logic kind);
        @(negedge mclk);
        can_sync_valid = 1'b1;
        can_sync_type  = kind;
        @(negedge mclk);
        can_sync_valid = 1'b0;
        can_sync_type  = ~kind; // Stale type must not be trusted
    endtask

    // Stalling makes the reply queue back up
    always @(negedge mclk) begin
        tx_ready <= !stall;
    end

    // Collect replies
    always @(posedge mclk) begin
        if (tx_valid && tx_ready) begin
            words     <= words + 1;
            last_word <= tx_data;
        end
    end
endmodule

// >>> tb/can_synced_position_reference_test.sv
`timescale 1ns/100ps
module can_synced_position_reference_test;
    logic        mclk, resetn, par_wr, par_rd, par_rvalid, can_sync_valid, can_sync_type;
    logic        tx_valid, tx_ready, reply_status_byte, virtual_table_enable, sync_latch_flag;
    logic [1:0]  bitrate_code, cam2_table_sel;
    logic [3:0]  operating_mode;
    logic [7:0]  par_addr;
    logic [15:0] par_wdata, par_rdata, speed_request_value, reply_status;
    logic [31:0] resolver_pos, encoder_pos, first_cam_generator_delta, cam2_delta, positioner_delta, tx_data;
    int          num_errors = 0;
    int          compares = 0;
    int          exp_words = 0;
    logic [39:0] rows [8] = '{{8'h68, 16'h0064, 16'h0064}, {8'h68, 16'h2ee0, 16'h2328},
        {8'h68, 16'hd120, 16'hdcd8}, {8'h69, 16'h0010, 16'h0010}, {8'h66, 16'h1234, 16'h1234},
        {8'h67, 16'h1234, 16'h1234}, {8'h3c, 16'h5555, 16'h0000}, {8'hc8, 16'habcd, 16'h0000}};
    logic [17:0] tx_cases [4] = '{{16'h0004, 1'b1, 1'b0}, {16'h0040, 1'b1, 1'b1},
        {16'h0040, 1'b0, 1'b0}, {16'h0044, 1'b0, 1'b1}};

    csp_position_ref dut_u (
        .mclk, .resetn, .operating_mode, .par_wr, .par_rd, .par_addr, .par_wdata, .par_rdata, .par_rvalid,
        .can_sync_valid, .can_sync_type, .resolver_pos, .encoder_pos, .first_cam_generator_delta, .cam2_delta, .positioner_delta,
        .tx_valid, .tx_ready, .tx_data, .speed_request_value, .reply_status, .reply_status_byte, .bitrate_code,
        .cam2_table_sel, .virtual_table_enable, .sync_latch_flag
    );
    csp_can_master u_master (.mclk, .tx_valid, .tx_data, .can_sync_valid, .can_sync_type, .tx_ready);

    // --------
    // Helpers
    // --------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Strobes drop a full cycle before the next request
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk);
        par_wr    = 1'b1;
        par_addr  = a;
        par_wdata = d;
        @(negedge mclk);
        par_wr = 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(negedge mclk);
        par_rd   = 1'b1;
        par_addr = a;
        @(negedge mclk);
        par_rd = 1'b0;
        check("par_rvalid", {31'h0, par_rvalid}, 32'h1);
        check($sformatf("param %0d", a), {16'h0, par_rdata}, exp);
    endtask

    task automatic do_reset();
        @(negedge mclk);
        resetn = 1'b0;
        idle(6);
        resetn = 1'b1;
        check("bitrate_code", {30'h0, bitrate_code}, 32'h1);
        check("cam2_table_sel", {30'h0, cam2_table_sel}, 32'h3);
        check("virtual_table_enable", {31'h0, virtual_table_enable}, 32'h0);
        check("tx_valid", {31'h0, tx_valid}, 32'h0);
        for (int a = 8'h66; a < 8'h76; a++) if (a < 8'h6a || a > 8'h71) rchk(a[7:0], 32'h0);
        $display("test reset done");
    endtask

    // Bounded wait for replies at the master
    task automatic wait_words(input int n);
        for (int k = 0; k < 200 && u_master.words != n; k++) @(negedge mclk);
        check("reply words", u_master.words, n);
        if (u_master.words != n) give_verdict();
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // --------
    // Main sequence
    // --------
    initial begin
        {resetn, operating_mode, par_wr, par_rd, par_addr, par_wdata} = '0;
        {resolver_pos, encoder_pos, first_cam_generator_delta, cam2_delta, positioner_delta} = '0;
        do_reset();
        foreach (rows[i]) begin
            wr(rows[i][39:32], rows[i][31:16]);
            rchk(rows[i][39:32], {16'h0, rows[i][15:0]});
        end
        $display("test table done");
        operating_mode = 4'hf;
        resolver_pos   = 32'h20;
        wr(8'h69, 16'h0064);
        wr(8'h72, 16'h0010);
        wr(8'h73, 16'h0000);
        wr(8'h96, 16'h0004);
        u_master.send_sync(1'b0);
        idle(2);
        rchk(8'h68, 32'h64);
        rchk(8'h3c, 32'h10);
        rchk(8'h74, 32'h20);
        check("reply word", u_master.last_word, 32'h20);
        wr(8'h69, 16'h00c8);
        idle(2);
        rchk(8'h68, 32'h64);
        check("speed", {16'h0, speed_request_value}, 32'h63);
        // Sync started by a parameter write, no reply queued
        wr(8'h96, 16'h0100);
        rchk(8'h68, 32'hc8);
        exp_words = 1;
        foreach (tx_cases[i]) begin
            wr(8'h96, tx_cases[i][17:2]);
            u_master.send_sync(tx_cases[i][1]);
            idle(4);
            exp_words += tx_cases[i][0];
            check("reply words", u_master.words, exp_words);
        end
        $display("test sync done");
        for (int j = 0; j < 3; j++) begin
            wr(8'h30, {15'h0, j == 2});
            wr(8'h96, (j == 1) ? 16'h0000 : 16'h0010);
            idle(2);
            check("bitrate_code", {30'h0, bitrate_code}, (j == 0) ? 32'h2 : (j == 1) ? 32'h1 : 32'h0);
        end
        wr(8'h30, 16'h0000);
        check("reply_status", {16'h0, reply_status}, 32'h1234);
        wr(8'h96, 16'h0008);
        idle(2);
        check("reply_status", {16'h0, reply_status}, 32'h0034);
        check("reply_status_byte", {31'h0, reply_status_byte}, 32'h1);
        wr(8'h1c, 16'h0100);
        encoder_pos = 32'h5;
        wr(8'h96, 16'h0800);
        idle(2);
        rchk(8'h3e, 32'h100);
        rchk(8'h3c, 32'h100);
        rchk(8'h40, 32'h0);
        resolver_pos = 32'h30;
        encoder_pos  = 32'h8;
        wr(8'h96, 16'h1000);
        idle(2);
        rchk(8'h3c, 32'h110);
        rchk(8'h40, 32'h0);
        wr(8'h96, 16'h0400);
        idle(2);
        rchk(8'h3e, 32'h0);
        rchk(8'h3c, 32'h0);
        wr(8'h46, 16'h0002);
        encoder_pos  = 32'hb;
        resolver_pos = 32'h40;
        idle(2);
        rchk(8'h3e, 32'h3);
        $display("test position resets done");
        for (int i = 0; i < 3; i++) begin
            wr(8'hb5, 16'h2200 << i);
            {positioner_delta, cam2_delta, first_cam_generator_delta} = 96'h1 << (32 * i);
            idle(4);
            {positioner_delta, cam2_delta, first_cam_generator_delta} = 96'h0;
            rchk(8'h82, 4 * (i + 1));
            rchk(8'h3c, 4 * (i + 1));
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'hb5, {7'h0, k[0], k[1], k[0], 6'h0});
            check("cam2_table_sel", {30'h0, cam2_table_sel}, {30'h0, ~k[0], ~k[1]});
            check("virtual_table_enable", {31'h0, virtual_table_enable}, {31'h0, k[0]});
        end
        $display("test cams done");
        // 32 fill the queue, one waits, one merges into it
        wr(8'h96, 16'h0004);
        u_master.stall = 1'b1;
        repeat (34) u_master.send_sync(1'b0);
        idle(2);
        check("sync_latch_flag", {31'h0, sync_latch_flag}, 32'h1);
        check("tx_valid", {31'h0, tx_valid}, 32'h1);
        u_master.stall = 1'b0;
        wait_words(exp_words + 33);
        idle(2);
        check("sync_latch_flag", {31'h0, sync_latch_flag}, 32'h0);
        check("tx_valid", {31'h0, tx_valid}, 32'h0);
        $display("test queue done");
        do_reset();
        give_verdict();
    end
endmodule
